// *** ccu_pin_src.sv ***
`timescale 1ns/1ns
`default_nettype none
// far side of the pin: follows the level at once or three clocks late
module ccu_pin_src (
  input wire logic i_clk,
  input wire logic i_level,
  input wire logic i_slow,
  output logic o_pin
);
  logic [2:0] dly = 3'h0;
  always @(posedge i_clk) begin
    dly <= {dly[1:0], i_level};
  end
  assign o_pin = i_slow ? dly[2] : i_level;
endmodule // ccu_pin_src
`default_nettype wire

// *** ccu_pkg.sv ***
package ccu_pkg;
  localparam logic [7:0] ccu_off_flags = 8'h0c;
  localparam logic [7:0] ccu_off_tmr_lo = 8'h0e;
  localparam logic [7:0] ccu_off_tmr_hi = 8'h0f;
  localparam logic [7:0] ccu_off_val_lo = 8'h15;
  localparam logic [7:0] ccu_off_val_hi = 8'h16;
  localparam logic [7:0] ccu_off_ctrl = 8'h17;
  localparam logic [7:0] ccu_off_enables = 8'h8c;
  localparam int ccu_irq_bit = 2;
  localparam logic [7:0] ccu_flags_mask = 8'h04;
  localparam logic [5:0] ccu_ctrl_rst = 6'h00;
  localparam logic [7:0] ccu_flags_rst = 8'h00;
  localparam logic [3:0] ccu_presc_div4 = 4'h3;
  localparam logic [3:0] ccu_presc_div16 = 4'hf;
  typedef enum logic [3:0] {
    ccu_off = 4'b0000,
    ccu_cap_fall = 4'b0100,
    ccu_cap_rise = 4'b0101,
    ccu_cap_rise4 = 4'b0110,
    ccu_cap_rise16 = 4'b0111,
    ccu_cmp_set = 4'b1000,
    ccu_cmp_clr = 4'b1001,
    ccu_cmp_soft = 4'b1010,
    ccu_cmp_trig = 4'b1011
  } ccu_mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccu_bus_t;
endpackage

// *** ccu_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// Contract
// - value register as two byte registers
// - four bit mode field, 11xx does nothing
// - mode 0000 turns unit off, resets
// - capture edge select by mode code
// - compare sets or clears pin, flags
// - code 1010 only flags, pin kept
// - code 1011 trigger clears timer, starts conversion
// - value register acts as timer period in code 1011 only
// - duty low bits stored, unused otherwise
// - control bits 7:6 read zero
// - capture copies full timer count
// - capture sets flag until software clears
// - newer capture overwrites older value
// - capture sees pin level even driven
// - mode change may flag spuriously
// - prescaler zero when off or noncapture
// - prescale switch keeps count
// - compare flags every match
// - control zero forces output latch low
module ccu_top import ccu_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_pin,
  output logic [7:0] o_rdata,
  output logic o_pin,
  output logic o_irq_flag,
  output logic o_irq_enable,
  output logic o_adc_start,
  output logic [15:0] o_timer1_count
);
  ccu_bus_t bus;
  logic [15:0] timer1_count;
  logic [15:0] capcmp_value;
  logic [5:0] ctrl;
  logic [7:0] flags;
  logic [7:0] enables;
  logic [3:0] presc;
  logic pin_s1;
  logic pin_s2;
  logic pin_d;
  logic out_latch;
  logic trig;
  logic [7:0] rdata;
  logic irq_flag_q;
  logic adc_q;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  wire logic [3:0] mode = ctrl[3:0];
  wire logic is_capture = (mode[3:2] == 2'b01);
  wire logic is_compare = (mode[3:2] == 2'b10);
  wire logic wr_flags = bus.wr && (bus.addr == ccu_off_flags);
  wire logic wr_tlo = bus.wr && (bus.addr == ccu_off_tmr_lo);
  wire logic wr_thi = bus.wr && (bus.addr == ccu_off_tmr_hi);
  wire logic wr_vlo = bus.wr && (bus.addr == ccu_off_val_lo);
  wire logic wr_vhi = bus.wr && (bus.addr == ccu_off_val_hi);
  wire logic wr_ctrl = bus.wr && (bus.addr == ccu_off_ctrl);
  wire logic wr_en = bus.wr && (bus.addr == ccu_off_enables);
  wire logic wr_timer = wr_tlo || wr_thi;

  wire logic rise = pin_s2 && !pin_d;
  wire logic fall = !pin_s2 && pin_d;
  wire logic presc_hit4 = (presc[1:0] == ccu_presc_div4[1:0]);
  wire logic presc_hit16 = (presc == ccu_presc_div16);
  wire logic cap_event =
    (mode == ccu_cap_fall && fall) ||
    (mode == ccu_cap_rise && rise) ||
    (mode == ccu_cap_rise4 && rise && presc_hit4) ||
    (mode == ccu_cap_rise16 && rise && presc_hit16);
  wire logic match = is_compare && (capcmp_value == timer1_count);
  wire logic set_irq = cap_event || match;
  wire logic next_trig = match && (mode == ccu_cmp_trig);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_d <= 1'b0;
    end else begin
      pin_s1 <= i_pin;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      presc <= 4'h0;
    end else if (!is_capture) begin
      presc <= 4'h0;
    end else if (rise) begin
      presc <= presc + 4'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      timer1_count <= 16'h0000;
    end else if (wr_tlo) begin
      timer1_count[7:0] <= bus.wdata;
    end else if (wr_thi) begin
      timer1_count[15:8] <= bus.wdata;
    end else if (trig) begin
      timer1_count <= 16'h0000;
    end else begin
      timer1_count <= timer1_count + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      capcmp_value <= 16'h0000;
    end else if (cap_event) begin
      capcmp_value <= timer1_count;
    end else if (wr_vlo) begin
      capcmp_value[7:0] <= bus.wdata;
    end else if (wr_vhi) begin
      capcmp_value[15:8] <= bus.wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl <= ccu_ctrl_rst;
    end else if (wr_ctrl) begin
      ctrl <= bus.wdata[5:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flags <= ccu_flags_rst;
      enables <= ccu_flags_rst;
    end else begin
      if (wr_flags) begin
        flags <= (bus.wdata & ccu_flags_mask) | (set_irq ? ccu_flags_mask : 8'h00);
      end else if (set_irq) begin
        flags[ccu_irq_bit] <= 1'b1;
      end
      if (wr_en) begin
        enables <= bus.wdata & ccu_flags_mask;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      out_latch <= 1'b0;
    end else if (wr_ctrl && bus.wdata == 8'h00) begin
      out_latch <= 1'b0;
    end else if (mode == ccu_off) begin
      out_latch <= 1'b0;
    end else if (match && mode == ccu_cmp_set) begin
      out_latch <= 1'b1;
    end else if (match && mode == ccu_cmp_clr) begin
      out_latch <= 1'b0;
    end
  end

  // read mux, upper control bits zero
  always_comb begin
    unique case (bus.addr)
      ccu_off_flags: rdata = flags;
      ccu_off_tmr_lo: rdata = timer1_count[7:0];
      ccu_off_tmr_hi: rdata = timer1_count[15:8];
      ccu_off_val_lo: rdata = capcmp_value[7:0];
      ccu_off_val_hi: rdata = capcmp_value[15:8];
      ccu_off_ctrl: rdata = {2'b00, ctrl};
      ccu_off_enables: rdata = enables;
      default: rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      trig <= 1'b0;
      adc_q <= 1'b0;
    end else begin
      o_rdata <= bus.rd ? rdata : 8'h00;
      trig <= next_trig && !wr_timer;
      adc_q <= next_trig;
    end
  end

  assign o_pin = out_latch;
  assign o_irq_flag = flags[ccu_irq_bit];
  assign o_irq_enable = enables[ccu_irq_bit];
  assign o_adc_start = adc_q;
  assign o_timer1_count = timer1_count;

  cap_copy_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cap_event |=> capcmp_value == $past(timer1_count)) else $error("capture value wrong");
  cap_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cap_event |=> o_irq_flag) else $error("capture flag missing");
  cmp_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
    match |=> o_irq_flag) else $error("match flag missing");
  pin_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (match && mode == ccu_cmp_set && !wr_ctrl) |=> o_pin) else $error("pin not set");
  pin_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (mode == ccu_cmp_soft && !wr_ctrl) |=> o_pin == $past(o_pin)) else $error("pin changed");
  sequence trig_seq;
    match && mode == ccu_cmp_trig && !wr_timer;
  endsequence
  trig_clr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    trig_seq ##1 !wr_timer |=> timer1_count == 16'h0000) else $error("timer not cleared");
  presc_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !is_capture |=> presc == 4'h0) else $error("prescaler not zero");
  ctrl_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (bus.rd && bus.addr == ccu_off_ctrl) |=> o_rdata[7:6] == 2'b00) else $error("reserved bits set");
  ctrl_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_ctrl && bus.wdata == 8'h00) |=> !o_pin) else $error("latch not low");

  sequence rise_seq;
    is_capture && rise;
  endsequence
  sequence hold_seq;
    is_capture && !rise;
  endsequence
  sequence fire_seq;
    next_trig;
  endsequence

  val_lo_wr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_vlo && !cap_event) |=> capcmp_value[7:0] == $past(bus.wdata)) else $error("low byte not written");

  val_hi_wr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_vhi && !cap_event) |=> capcmp_value[15:8] == $past(bus.wdata)) else $error("high byte not written");

  val_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!wr_vlo && !wr_vhi && !cap_event) |=> capcmp_value == $past(capcmp_value)) else $error("value drifted");

  rd_vlo_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (bus.rd && bus.addr == ccu_off_val_lo) |=> o_rdata == $past(capcmp_value[7:0])) else $error("low read wrong");

  rd_vhi_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (bus.rd && bus.addr == ccu_off_val_hi) |=> o_rdata == $past(capcmp_value[15:8])) else $error("high read wrong");

  ctrl_wr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_ctrl |=> ctrl == $past(bus.wdata[5:0])) else $error("control not stored");

  pwm_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (mode[3:2] == 2'b11) |-> !match && !cap_event) else $error("pwm code acted");

  ctrl_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !wr_ctrl |=> ctrl == $past(ctrl)) else $error("control drifted");

  off_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (mode == ccu_off && !wr_ctrl) |=> !o_pin) else $error("off latch high");

  off_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (mode == ccu_off) |-> !cap_event && !match) else $error("off unit active");

  fall_cap_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (mode == ccu_cap_fall && fall) |-> cap_event) else $error("fall missed");

  rise_cap_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (mode == ccu_cap_rise && rise) |-> cap_event) else $error("rise missed");

  fall_only_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (mode == ccu_cap_fall && rise) |-> !cap_event) else $error("rise captured");

  presc4_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (mode == ccu_cap_rise4 && cap_event) |-> presc[1:0] == 2'b11) else $error("div4 early");

  presc16_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (mode == ccu_cap_rise16 && cap_event) |-> presc == 4'hf) else $error("div16 early");

  cap_pin_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (is_capture && !wr_ctrl) |=> o_pin == $past(o_pin)) else $error("capture moved latch");

  pin_clr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (match && mode == ccu_cmp_clr) |=> !o_pin) else $error("pin not cleared");

  soft_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (match && mode == ccu_cmp_soft) |=> o_irq_flag) else $error("soft flag missing");

  trig_adc_a: assert property (@(posedge i_clk) disable iff (i_rst)
    fire_seq |=> o_adc_start) else $error("no conversion start");

  adc_src_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_adc_start |-> $past(next_trig)) else $error("stray conversion");

  trig_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (match && mode == ccu_cmp_trig) |=> o_irq_flag) else $error("trigger flag missing");

  trig_wr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (trig && wr_tlo) |=> timer1_count[7:0] == $past(bus.wdata)) else $error("write lost");

  tmr_inc_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!wr_timer && !trig) |=> timer1_count == $past(timer1_count) + 16'h0001) else $error("timer stalled");

  rd_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !bus.rd |=> o_rdata == 8'h00) else $error("read data not zero");

  flag_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_irq_flag && !wr_flags) |=> o_irq_flag) else $error("flag dropped");

  flag_clr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_flags && !bus.wdata[ccu_irq_bit] && !set_irq) |=> !o_irq_flag) else $error("flag not cleared");

  flag_bits_a: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |-> (flags & ~ccu_flags_mask) == 8'h00) else $error("stray flag bits");

  cap_wins_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (cap_event && wr_vlo) |=> capcmp_value == $past(timer1_count)) else $error("write beat capture");

  presc_cnt_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rise_seq |=> presc == $past(presc) + 4'h1) else $error("prescaler missed rise");

  presc_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    hold_seq |=> presc == $past(presc)) else $error("prescaler drifted");

  sync_pipe_a: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> pin_s2 == $past(pin_s1)) else $error("sync stage wrong");

  edge_need_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cap_event |-> rise || fall) else $error("capture without edge");
endmodule // ccu_top
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top import ccu_pkg::*;;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic lvl = 1'b0;
  logic slow = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic pin, o_pin, o_irq_flag, o_irq_enable, o_adc_start;
  logic [7:0] o_rdata;
  logic [15:0] o_timer1_count, t, d;
  logic [31:0] rs = 32'hb7b46ecf;
  logic [15:0] eq[$];
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  logic [3:0] cm[5] = '{4'h8, 4'ha, 4'h9, 4'h8, 4'h0};
  logic cp[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  ccu_pin_src src_u (.i_clk(i_clk), .i_level(lvl), .i_slow(slow), .o_pin(pin));
  ccu_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_pin(pin), .o_rdata(o_rdata), .o_pin(o_pin), .o_irq_flag(o_irq_flag), .o_irq_enable(o_irq_enable),
    .o_adc_start(o_adc_start), .o_timer1_count(o_timer1_count));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    rd_q <= i_rd;
    if (!i_rst) cyc <= cyc + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // read data against oldest note, with tolerance
  always @(negedge i_clk) begin
    if (rd_q) begin
      d = eq.pop_front();
      chk(8'(o_rdata - d[15:8]) <= d[7:0], "read data");
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] tol);
    eq.push_back({e, tol});
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("tests %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(ccu_off_ctrl, 8'h00, 8'h00);
    rd(8'h00, 8'h00, 8'h00);
    wr(ccu_off_ctrl, 8'hff);
    rd(ccu_off_ctrl, 8'h3f, 8'h00);
    wr(ccu_off_enables, 8'h04);
    rd(ccu_off_enables, 8'h04, 8'h00);
    #1 chk(o_irq_enable === 1'b1, "enable output");
    repeat (4) begin
      rs = xs(rs);
      wr(ccu_off_val_lo, rs[7:0]);
      wr(ccu_off_val_hi, rs[15:8]);
      rd(ccu_off_val_lo, rs[7:0], 8'h00);
      rd(ccu_off_val_hi, rs[15:8], 8'h00);
    end
    $display("test registers done");
    for (int m = 4; m < 8; m++) begin
      wr(ccu_off_ctrl, 8'h00);
      lvl <= (m == 4);
      repeat (8) @(posedge i_clk);
      wr(ccu_off_ctrl, 8'(m));
      wr(ccu_off_flags, 8'h00);
      n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
      for (int k = 1; k <= n; k++) begin
        slow <= k[0];
        lvl <= (m != 4);
        t = 16'(cyc) + (k[0] ? 16'h0003 : 16'h0000);
        repeat (10) @(posedge i_clk);
        #1 chk(o_irq_flag === (k == n), "flag output");
        rd(ccu_off_flags, (k == n) ? 8'h04 : 8'h00, 8'h00);
        lvl <= (m == 4);
        repeat (10) @(posedge i_clk);
      end
      rd(ccu_off_val_lo, t[7:0] + 8'h02, 8'h05);
      rd(ccu_off_val_hi, t[15:8], 8'h01);
    end
    $display("test capture done");
    wr(ccu_off_val_hi, 8'h00);
    wr(ccu_off_val_lo, 8'h28);
    for (int i = 0; i < 5; i++) begin
      wr(ccu_off_flags, 8'h00);
      wr(ccu_off_tmr_hi, 8'h00);
      wr(ccu_off_tmr_lo, 8'h00);
      wr(ccu_off_ctrl, {4'h0, cm[i]});
      repeat (60) @(posedge i_clk);
      #1 chk(o_pin === cp[i], "compare pin");
      rd(ccu_off_flags, (cm[i] != 4'h0) ? 8'h04 : 8'h00, 8'h00);
    end
    wr(ccu_off_tmr_hi, 8'h00);
    wr(ccu_off_tmr_lo, 8'h00);
    wr(ccu_off_val_lo, 8'h14);
    wr(ccu_off_ctrl, 8'h0b);
    repeat (40) @(posedge i_clk);
    n = 0;
    repeat (220) begin
      @(posedge i_clk);
      #1;
      n += int'(o_adc_start);
      chk(o_timer1_count <= 16'h0015, "timer period");
    end
    chk(n === 10, "trigger period");
    rd(ccu_off_flags, 8'h04, 8'h00);
    $display("test compare done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
